// ### lsg_top.v
// limited speed guard: four channels, per-channel limits, escalation and register port
// assumes requests and ack arrive on pins, speed and modulation come from logic on clk
`timescale 1ns/1ns
`include "lsg_map.vh"

// How it works
// - several channels active: smallest limit is the effective limit
// - several channels active: trip on the lowest active trip limit
// - request above limit: decelerate under timed window or ramp envelope
// - timed window: emergency stop if speed still above trip limit when time expires
// - ramp mode: torque cutoff when speed leaves the ramp envelope
// - immediate start needs timed window with zero delay
// - supervision active: emergency stop when speed reaches trip limit
// - configuration chooses modulation-loss cutoff indication, reaction and delay
// - speed already under limit: supervise at once, indicate active
// - manual acknowledge: removal keeps supervision until acknowledged
// - automatic acknowledge: removal ends supervision at once
// - acknowledge stops supervision and drops the active indication
// - modulation loss while active below limit: no cutoff, stay active
// - timed window above limit: start the start-delay counter
// - supervision begins at midpoint between limit and trip limit
// - timed window: supervision starts at latest when delay expires
// - speed above trip at delay expiry: emergency stop
// - ramp mode: stop envelope checking once supervision begins
// - modulation loss reaction: delay, monitor, both or neither; default delay 0 ms
module lsg_top #(
  parameter MS_CYCLES = `LSG_MS_NS / `LSG_CLK_PERIOD_NS
) (
  input wire clk,
  input wire reset,
  input wire [4:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [3:0] guard_request,
  input wire guard_ack,
  input wire speed_valid,
  input wire [15:0] speed_sample,
  input wire [15:0] ramp_env_min,
  input wire [15:0] ramp_env_max,
  input wire modulation_on,
  output wire [3:0] guard_active_indication,
  output wire ramp_supervision_one_enable,
  output wire emergency_stop_function,
  output wire torque_cutoff,
  output wire modloss_cutoff_indication,
  output reg [15:0] effective_limit
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function [15:0] mag16;
    input [15:0] v;
    begin
      mag16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  function [15:0] min16;
    input [15:0] a;
    input [15:0] b;
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg [3:0] req_s1_q;
  reg [3:0] req_s2_q;
  reg ack_s1_q;
  reg ack_s2_q;
  reg ack_s3_q;
  wire ack_pulse;

  always @(posedge clk)
  begin
    if (reset)
    begin
      req_s1_q <= 4'h0;
      req_s2_q <= 4'h0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= guard_request;
      req_s2_q <= req_s1_q;
      ack_s1_q <= guard_ack;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  assign ack_pulse = ack_s2_q && !ack_s3_q;

  ////////////////////////////////////////////////////////////////////////////////
  // millisecond tick

  reg [31:0] div_q;
  reg ms_tick_q;

  always @(posedge clk)
  begin
    if (reset)
    begin
      div_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
    end
    else if (div_q >= MS_CYCLES - 1)
    begin
      div_q <= 32'h00000000;
      ms_tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 32'h00000001;
      ms_tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  reg [15:0] limit_q [0:3];
  reg [15:0] trip_q [0:3];
  reg [3:0] cfg_q;
  reg [15:0] start_delay_q;
  reg [15:0] modoff_delay_q;
  reg [15:0] speed_q;
  reg estop_q;
  reg cutoff_q;
  reg mloss_q;
  reg [15:0] ml_cnt_q;
  wire [3:0] active;
  wire [3:0] decel;
  wire [3:0] ramp_chk;
  wire [3:0] env_cut;
  wire [3:0] late_trip;
  wire [3:0] ml_pending;
  wire [15:0] spd_mag;
  wire env_ok;
  wire wr_limit;
  wire wr_trip;
  wire [1:0] wr_ch;
  wire clr_estop;
  wire clr_cutoff;
  wire clr_mloss;
  reg [15:0] eff_trip;
  reg [15:0] eff_lim_d;
  reg any_guard;
  integer i;
  integer j;

  assign spd_mag = mag16(speed_sample);
  assign env_ok = ($signed(speed_sample) >= $signed(ramp_env_min)) &&
    ($signed(speed_sample) <= $signed(ramp_env_max));
  assign wr_limit = reg_wr && (reg_addr < `LSG_REG_CONFIG) && !reg_addr[0];
  assign wr_trip = reg_wr && (reg_addr < `LSG_REG_CONFIG) && reg_addr[0];
  assign wr_ch = reg_addr[2:1];
  assign clr_estop = reg_wr && (reg_addr == `LSG_REG_STATUS) && reg_wdata[`LSG_ST_ESTOP];
  assign clr_cutoff = reg_wr && (reg_addr == `LSG_REG_STATUS) && reg_wdata[`LSG_ST_CUTOFF];
  assign clr_mloss = reg_wr && (reg_addr == `LSG_REG_STATUS) && reg_wdata[`LSG_ST_MLOSS];

  always @(posedge clk)
  begin
    if (reset)
    begin
      for (i = 0; i < `LSG_CHANNELS; i = i + 1)
      begin
        limit_q[i] <= `LSG_RST_LIMIT;
        trip_q[i] <= `LSG_RST_TRIP;
      end
      cfg_q <= `LSG_RST_CONFIG;
      start_delay_q <= `LSG_RST_START_DELAY;
      modoff_delay_q <= `LSG_RST_MODOFF_DELAY;
      speed_q <= 16'h0000;
    end
    else
    begin
      if (wr_limit)
        limit_q[wr_ch] <= reg_wdata[15:0];
      if (wr_trip)
        trip_q[wr_ch] <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `LSG_REG_CONFIG)
        cfg_q <= reg_wdata[3:0];
      if (reg_wr && reg_addr == `LSG_REG_START_DELAY)
        start_delay_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `LSG_REG_MODOFF_DELAY)
        modoff_delay_q <= reg_wdata[15:0];
      if (speed_valid)
        speed_q <= speed_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channels

  genvar g;
  generate
    for (g = 0; g < `LSG_CHANNELS; g = g + 1)
    begin : ch
      lsg_chan u_chan (
        .clk(clk),
        .reset(reset),
        .req(req_s2_q[g]),
        .ack(ack_pulse),
        .auto_ack(cfg_q[`LSG_CFG_AUTO_ACK]),
        .ramp_mode(cfg_q[`LSG_CFG_RAMP_MODE]),
        .ml_react(cfg_q[`LSG_CFG_ML_HI:`LSG_CFG_ML_LO]),
        .start_delay(start_delay_q),
        .ms_tick(ms_tick_q),
        .spd_valid(speed_valid),
        .spd(spd_mag),
        .limit(limit_q[g]),
        .trip(trip_q[g]),
        .env_ok(env_ok),
        .mod_on(modulation_on),
        .active(active[g]),
        .decel(decel[g]),
        .ramp_chk(ramp_chk[g]),
        .env_cut(env_cut[g]),
        .late_trip(late_trip[g]),
        .ml_pending(ml_pending[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // effective limit over active and decelerating channels, trip limit over active ones

  always @*
  begin
    eff_lim_d = `LSG_RST_LIMIT;
    eff_trip = `LSG_RST_TRIP;
    any_guard = 1'b0;
    for (j = 0; j < `LSG_CHANNELS; j = j + 1)
    begin
      if (active[j] || decel[j])
        eff_lim_d = min16(eff_lim_d, limit_q[j]);
      if (active[j])
      begin
        eff_trip = min16(eff_trip, trip_q[j]);
        any_guard = 1'b1;
      end
    end
  end

  // limit handed to the drive comes from a flop
  always @(posedge clk)
  begin
    if (reset)
      effective_limit <= `LSG_RST_LIMIT;
    else
      effective_limit <= eff_lim_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // escalation: emergency stop, torque cutoff, modulation-loss indication

  wire [16:0] ml_inc;
  wire trip_hit;

  assign ml_inc = {1'b0, ml_cnt_q} + 17'h00001;
  assign trip_hit = any_guard && speed_valid && (spd_mag >= eff_trip);

  always @(posedge clk)
  begin
    if (reset)
    begin
      estop_q <= 1'b0;
      cutoff_q <= 1'b0;
      mloss_q <= 1'b0;
      ml_cnt_q <= 16'h0000;
    end
    else
    begin
      if (trip_hit || (|late_trip))
        estop_q <= 1'b1;
      else if (clr_estop)
        estop_q <= 1'b0;
      if (|env_cut)
        cutoff_q <= 1'b1;
      else if (clr_cutoff)
        cutoff_q <= 1'b0;
      // channels that lost modulation while decelerating count, also once active; loss first seen while active is ignored
      if (!(|ml_pending))
        ml_cnt_q <= 16'h0000;
      else if (ml_cnt_q >= modoff_delay_q)
        mloss_q <= 1'b1;
      else if (ms_tick_q)
        ml_cnt_q <= ml_inc[15:0];
      if (clr_mloss && !((|ml_pending) && ml_cnt_q >= modoff_delay_q))
        mloss_q <= 1'b0;
    end
  end

  assign guard_active_indication = active;
  assign ramp_supervision_one_enable = |ramp_chk;
  assign emergency_stop_function = estop_q;
  assign torque_cutoff = cutoff_q;
  assign modloss_cutoff_indication = mloss_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read port

  always @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      reg_rdata <= 32'h00000000;
      if (reg_addr < `LSG_REG_CONFIG)
        reg_rdata <= {16'h0000, reg_addr[0] ? trip_q[reg_addr[2:1]] : limit_q[reg_addr[2:1]]};
      else
        case (reg_addr)
          `LSG_REG_CONFIG: reg_rdata <= {28'h0000000, cfg_q};
          `LSG_REG_START_DELAY: reg_rdata <= {16'h0000, start_delay_q};
          `LSG_REG_MODOFF_DELAY: reg_rdata <= {16'h0000, modoff_delay_q};
          `LSG_REG_STATUS: reg_rdata <= {21'h000000, mloss_q, cutoff_q, estop_q, decel, active};
          `LSG_REG_EFFECTIVE: reg_rdata <= {eff_trip, effective_limit};
          `LSG_REG_SPEED: reg_rdata <= {16'h0000, speed_q};
          default: reg_rdata <= 32'h00000000;
        endcase
    end
  end

endmodule // lsg_top

// ### lsg_map.vh
// register map, field positions, reset values and timing constants of the limited speed guard
// assumes word-indexed register port, 32-bit data, 100 MHz clock
`ifndef LSG_MAP_VH
`define LSG_MAP_VH

// register word indices
`define LSG_REG_LIMIT0 5'h00
`define LSG_REG_TRIP0 5'h01
`define LSG_REG_LIMIT1 5'h02
`define LSG_REG_TRIP1 5'h03
`define LSG_REG_LIMIT2 5'h04
`define LSG_REG_TRIP2 5'h05
`define LSG_REG_LIMIT3 5'h06
`define LSG_REG_TRIP3 5'h07
`define LSG_REG_CONFIG 5'h08
`define LSG_REG_START_DELAY 5'h09
`define LSG_REG_MODOFF_DELAY 5'h0a
`define LSG_REG_STATUS 5'h0b
`define LSG_REG_EFFECTIVE 5'h0c
`define LSG_REG_SPEED 5'h0d

// config fields
`define LSG_CFG_RAMP_MODE 0
`define LSG_CFG_AUTO_ACK 1
`define LSG_CFG_ML_LO 2
`define LSG_CFG_ML_HI 3

// modulation-loss reaction encoding: bit0 delay, bit1 monitoring kept active
`define LSG_ML_DELAY 2'h1
`define LSG_ML_MONITOR 2'h2
`define LSG_ML_BOTH 2'h3
`define LSG_ML_NONE 2'h0

// status fields
`define LSG_ST_ACTIVE_LO 0
`define LSG_ST_DECEL_LO 4
`define LSG_ST_ESTOP 8
`define LSG_ST_CUTOFF 9
`define LSG_ST_MLOSS 10

// reset values
`define LSG_RST_LIMIT 16'h7fff
`define LSG_RST_TRIP 16'h7fff
`define LSG_RST_CONFIG 4'h4
`define LSG_RST_START_DELAY 16'h0000
`define LSG_RST_MODOFF_DELAY 16'h0000

// timing
`define LSG_CLK_PERIOD_NS 10
`define LSG_MS_NS 1000000
`define LSG_CHANNELS 4

`endif

// ### lsg_chan.v
// one limited speed guard channel: request, deceleration supervision, acknowledgement
// assumes a synchronised request and ack, and a speed magnitude compared live
`timescale 1ns/1ns
`include "lsg_map.vh"

module lsg_chan (
  input wire clk,
  input wire reset,
  input wire req,
  input wire ack,
  input wire auto_ack,
  input wire ramp_mode,
  input wire [1:0] ml_react,
  input wire [15:0] start_delay,
  input wire ms_tick,
  input wire spd_valid,
  input wire [15:0] spd,
  input wire [15:0] limit,
  input wire [15:0] trip,
  input wire env_ok,
  input wire mod_on,
  output wire active,
  output wire decel,
  output wire ramp_chk,
  output reg env_cut,
  output reg late_trip,
  output wire ml_pending
);

  localparam S_IDLE = 2'h0;
  localparam S_DECEL = 2'h1;
  localparam S_ACT = 2'h2;
  localparam S_HOLD = 2'h3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg ml_q;
  reg ml_d;
  wire [16:0] mid_sum;
  wire [15:0] mid;
  wire above_lim;
  wire at_mid;
  wire over_trip;
  wire [16:0] cnt_inc;
  wire expired;

  assign mid_sum = {1'b0, limit} + {1'b0, trip};
  assign mid = mid_sum[16:1];
  assign above_lim = spd > limit;
  assign at_mid = spd <= mid;
  assign over_trip = spd > trip;
  assign cnt_inc = {1'b0, cnt_q} + 17'h00001;
  assign expired = ms_tick && (cnt_inc >= {1'b0, start_delay});

  assign active = (state_q == S_ACT) || (state_q == S_HOLD);
  assign decel = state_q == S_DECEL;
  assign ramp_chk = decel && ramp_mode && mod_on && !ml_q;
  assign ml_pending = ml_q && ml_react[0];

  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    ml_d = ml_q;
    env_cut = 1'b0;
    late_trip = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        ml_d = 1'b0;
        cnt_d = 16'h0000;
        if (req)
        begin
          if (!above_lim || (!ramp_mode && start_delay == 16'h0000))
            state_d = S_ACT;
          else
            state_d = S_DECEL;
        end
      end
      S_DECEL:
      begin
        if (!req)
          state_d = auto_ack ? S_IDLE : S_HOLD;
        else if (!mod_on || ml_q)
        begin
          ml_d = 1'b1;
          if (ml_react[1])
            state_d = S_ACT;
        end
        else
        begin
          if (ramp_mode && spd_valid && !env_ok)
            env_cut = 1'b1;
          if (spd_valid && at_mid)
            state_d = S_ACT;
          else if (!ramp_mode && expired)
          begin
            state_d = S_ACT;
            late_trip = over_trip;
          end
          else if (!ramp_mode && ms_tick)
            cnt_d = cnt_inc[15:0];
        end
      end
      S_ACT:
      begin
        if (!req)
          state_d = auto_ack ? S_IDLE : S_HOLD;
      end
      S_HOLD:
      begin
        if (req)
          state_d = S_ACT;
        else if (ack)
          state_d = S_IDLE;
      end
      default:
        state_d = S_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= S_IDLE;
      cnt_q <= 16'h0000;
      ml_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ml_q <= ml_d;
    end
  end

endmodule // lsg_chan

// ### lsg_properties.sv
// port checker for the limited speed guard
// bound to lsg_top; sees its ports only
`timescale 1ns/1ns
`include "lsg_map.vh"
module lsg_properties (
  input wire clk,
  input wire reset,
  input wire [4:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire [3:0] guard_request,
  input wire speed_valid,
  input wire [15:0] speed_sample,
  input wire [15:0] ramp_env_min,
  input wire [15:0] ramp_env_max,
  input wire modulation_on,
  input wire [3:0] guard_active_indication,
  input wire ramp_supervision_one_enable,
  input wire emergency_stop_function,
  input wire torque_cutoff,
  input wire modloss_cutoff_indication
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire clr = reg_wr && reg_addr == `LSG_REG_STATUS;
  sequence s_out;
    $signed(speed_sample) < $signed(ramp_env_min) || $signed(speed_sample) > $signed(ramp_env_max);
  endsequence
  sequence s_brk;
    ramp_supervision_one_enable && speed_valid ##0 s_out;
  endsequence
  chk_env_cut: assert property (s_brk |=> torque_cutoff)
    else $error("no cutoff after envelope break");
  chk_cut_cause: assert property ($rose(torque_cutoff) |->
    $past(ramp_supervision_one_enable) && $past(speed_valid))
    else $error("cutoff without envelope check");
  chk_estop_hold: assert property (emergency_stop_function && !(clr && reg_wdata[`LSG_ST_ESTOP])
    |=> emergency_stop_function)
    else $error("stop dropped without clear");
  chk_cut_hold: assert property (torque_cutoff && !(clr && reg_wdata[`LSG_ST_CUTOFF])
    |=> torque_cutoff)
    else $error("cutoff dropped without clear");
  chk_env_mod: assert property (!modulation_on |=> !ramp_supervision_one_enable)
    else $error("envelope check without modulation");
  chk_ml_cause: assert property ($rose(modloss_cutoff_indication) |-> !$past(modulation_on))
    else $error("modloss indication without loss");
  chk_drop_off: assert property ($fell(guard_active_indication[0]) |-> !$past(guard_request[0], 2))
    else $error("active dropped while requested");
  chk_rise_req: assert property ($rose(guard_active_indication[0]) |-> $past(guard_request[0], 2))
    else $error("active without request");
endmodule // lsg_properties
bind lsg_top lsg_properties u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .guard_request(guard_request), .speed_valid(speed_valid), .speed_sample(speed_sample),
  .ramp_env_min(ramp_env_min), .ramp_env_max(ramp_env_max), .modulation_on(modulation_on),
  .guard_active_indication(guard_active_indication), .ramp_supervision_one_enable(ramp_supervision_one_enable),
  .emergency_stop_function(emergency_stop_function), .torque_cutoff(torque_cutoff),
  .modloss_cutoff_indication(modloss_cutoff_indication));

// ### lsg_drive_model.sv
// drive model: speed ramps down to the effective limit, envelope around it
// bench loads speeds, freezes the ramp or skews the envelope
`timescale 1ns/1ns
module lsg_drive_model (
  input wire clk,
  input wire reset,
  input wire load,
  input wire [15:0] load_val,
  input wire [15:0] tgt,
  input wire freeze,
  input wire env_bad,
  output reg speed_valid,
  output reg [15:0] speed_sample,
  output wire [15:0] ramp_env_min,
  output wire [15:0] ramp_env_max
);
  always @(posedge clk)
  begin
    speed_valid <= !reset;
    if (reset)
      speed_sample <= 16'h0000;
    else if (load)
      speed_sample <= load_val;
    else if (!freeze && $signed(speed_sample) > $signed(tgt))
      speed_sample <= speed_sample - 16'h0001;
  end
  // skewed envelope puts the speed below its minimum
  assign ramp_env_min = speed_sample + (env_bad ? 16'h0010 : 16'hfff0);
  assign ramp_env_max = speed_sample + 16'h0020;
endmodule // lsg_drive_model

// ### tb_top.sv
// self-checking bench for the limited speed guard
// drive model feeds speed and envelope, bench drives pins and registers
`timescale 1ns/1ns
`include "lsg_map.vh"
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] ra = 5'h00;
  logic [31:0] wd = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [3:0] req_p = 4'h0;
  logic ack_p = 1'b0;
  logic mod = 1'b1;
  logic ld = 1'b0;
  logic [15:0] ldv = 16'h0000;
  logic frz = 1'b0;
  logic bad = 1'b0;
  wire [31:0] rdata;
  wire [15:0] spd, emin, emax, eff;
  wire [3:0] gai;
  wire sv, rse, estop, cut, mli;
  wire [6:0] outs = {mli, cut, estop, gai};
  int err_count = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  lsg_top #(.MS_CYCLES(10)) dut (.clk(clk), .reset(reset), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata(rdata), .guard_request(req_p), .guard_ack(ack_p), .speed_valid(sv),
    .speed_sample(spd), .ramp_env_min(emin), .ramp_env_max(emax), .modulation_on(mod),
    .guard_active_indication(gai), .ramp_supervision_one_enable(rse), .emergency_stop_function(estop),
    .torque_cutoff(cut), .modloss_cutoff_indication(mli), .effective_limit(eff));
  lsg_drive_model drv (.clk(clk), .reset(reset), .load(ld), .load_val(ldv), .tgt(eff), .freeze(frz),
    .env_bad(bad), .speed_valid(sv), .speed_sample(spd), .ramp_env_min(emin), .ramp_env_max(emax));
  ////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task wr(input [4:0] a, input [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input [4:0] a, output [31:0] d);
    @(posedge clk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask
  task rq(input [3:0] m);
    @(posedge clk);
    req_p <= m;
  endtask
  task setv(input [15:0] v, input logic f);
    @(posedge clk);
    ld <= 1'b1;
    ldv <= v;
    frz <= f;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task rst(input int n);
    @(posedge clk);
    reset <= 1'b1;
    req_p <= 4'h0;
    mod <= 1'b1;
    bad <= 1'b0;
    repeat (n) @(posedge clk);
    reset <= 1'b0;
  endtask
  task setup(input [15:0] l, input [15:0] t, input [31:0] c, input [31:0] dl);
    rst(2);
    wr(`LSG_REG_LIMIT0, {16'h0000, l});
    wr(`LSG_REG_TRIP0, {16'h0000, t});
    wr(`LSG_REG_CONFIG, c);
    wr(`LSG_REG_START_DELAY, dl);
  endtask
  task wait_bit(input int k, input int n);
    repeat (n)
      if (outs[k] !== 1'b1)
        @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////
  task t_below;
    setup(16'h03e8, 16'h04b0, 32'h4, 32'h0);
    wr(`LSG_REG_LIMIT1, 32'h0320);
    wr(`LSG_REG_TRIP1, 32'h0514);
    setv(16'h01f4, 1'b0);
    rq(4'h1);
    tick(3);
    chk(gai[0] === 1'b1, "below limit not active");
    tick(1);
    chk(eff === 16'h03e8, "single limit");
    rq(4'h3);
    tick(4);
    chk(eff === 16'h0320, "lowest limit");
    @(posedge clk);
    mod <= 1'b0;
    tick(20);
    chk(gai[0] === 1'b1 && mli === 1'b0 && cut === 1'b0, "loss while active");
    @(posedge clk);
    mod <= 1'b1;
    rq(4'h2);
    tick(4);
    chk(gai[0] === 1'b1, "released without ack");
    @(posedge clk);
    ack_p <= 1'b1;
    tick(4);
    @(posedge clk);
    ack_p <= 1'b0;
    tick(4);
    chk(gai === 4'h2, "ack");
  endtask
  task t_trip;
    setup(16'h03e8, 16'h04b0, 32'h4, 32'h0);
    wr(`LSG_REG_LIMIT1, 32'h0320);
    wr(`LSG_REG_TRIP1, 32'h0384);
    setv(16'h01f4, 1'b0);
    rq(4'h3);
    tick(4);
    chk(estop === 1'b0, "early stop");
    setv(16'hfc4a, 1'b0);
    tick(1);
    chk(estop === 1'b1, "lowest trip, negative");
    setv(16'h01f4, 1'b0);
    wr(`LSG_REG_STATUS, 32'h00000700);
    tick(2);
    chk(estop === 1'b0, "stop under trip");
  endtask
  task t_delay;
    setup(16'h03e8, 16'h04b0, 32'h4, 32'h3);
    setv(16'h05dc, 1'b1);
    rq(4'h1);
    tick(10);
    chk(gai[0] === 1'b0 && estop === 1'b0, "delay running");
    wait_bit(0, 60);
    chk(gai[0] === 1'b1, "active at expiry");
    chk(estop === 1'b1, "above trip at expiry");
  endtask
  task t_mid;
    setup(16'h03e8, 16'h04b0, 32'h4, 32'h64);
    setv(16'h05dc, 1'b0);
    rq(4'h1);
    wait_bit(0, 600);
    chk(spd <= 16'h044c && spd >= 16'h0447, "midpoint start");
    chk(estop === 1'b0, "stop in decel");
  endtask
  task t_ramp;
    setup(16'h03e8, 16'h04b0, 32'h1, 32'h0);
    setv(16'h05dc, 1'b0);
    rq(4'h1);
    tick(6);
    chk(rse === 1'b1 && cut === 1'b0, "envelope checking");
    @(posedge clk);
    bad <= 1'b1;
    tick(2);
    chk(cut === 1'b1, "envelope cutoff");
    @(posedge clk);
    bad <= 1'b0;
    wait_bit(0, 600);
    chk(rse === 1'b0, "envelope on when active");
  endtask
  task t_auto;
    setup(16'h03e8, 16'h04b0, 32'h6, 32'h0);
    setv(16'h05dc, 1'b1);
    rq(4'h1);
    tick(3);
    chk(gai[0] === 1'b1, "zero delay start");
    rq(4'h0);
    tick(4);
    chk(gai[0] === 1'b0, "auto release");
  endtask
  task t_ml;
    logic [31:0] d;
    int r;
    rst(2);
    rd(`LSG_REG_CONFIG, d);
    chk(d === 32'h4, "config default");
    rd(`LSG_REG_MODOFF_DELAY, d);
    chk(d === 32'h0, "modoff delay default");
    rd(5'h1f, d);
    chk(d === 32'h0, "unmapped read");
    for (r = 0; r < 4; r++)
    begin
      setup(16'h03e8, 16'h04b0, {28'h0, r[1:0], 2'h1}, 32'h0);
      setv(16'h05dc, 1'b1);
      rq(4'h1);
      tick(6);
      @(posedge clk);
      mod <= 1'b0;
      tick(4);
      chk(mli === r[0] && gai[0] === r[1], "loss reaction");
    end
    // delayed indication: two ms before it shows
    setup(16'h03e8, 16'h04b0, 32'h5, 32'h0);
    wr(`LSG_REG_MODOFF_DELAY, 32'h2);
    setv(16'h05dc, 1'b1);
    rq(4'h1);
    tick(6);
    @(posedge clk);
    mod <= 1'b0;
    tick(4);
    chk(mli === 1'b0, "modoff delay early");
    tick(30);
    chk(mli === 1'b1, "modoff delay expiry");
  endtask
  task conclude;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_below();
    t_trip();
    t_delay();
    t_mid();
    t_ramp();
    t_auto();
    t_ml();
    conclude();
  end
  initial
  begin
    #200000;
    err_count++;
    conclude();
  end
endmodule // tb_top
